// file: hdl/dcp_pkg.sv
package dcp_pkg;
  localparam int NUM_CHAN = 8;
  localparam int COUNT_W  = 16;
  localparam int PAGE_W   = 8;

  // count ports, channel 7 down to 0
  localparam logic [7:0][15:0] COUNT_OFS = {
    16'h00ce, 16'h00ca, 16'h00c6, 16'h00c2,
    16'h0007, 16'h0005, 16'h0003, 16'h0001};
  // current address ports, only watched for pointer and page side effects
  localparam logic [7:0][15:0] ADDR_OFS = {
    16'h00cc, 16'h00c8, 16'h00c4, 16'h00c0,
    16'h0006, 16'h0004, 16'h0002, 16'h0000};
  // low page ports; channel 4 has none
  localparam logic [7:0][15:0] LOW_PAGE_OFS = {
    16'h008a, 16'h0089, 16'h008b, 16'h0000,
    16'h0082, 16'h0081, 16'h0083, 16'h0087};
  localparam logic [7:0][15:0] HIGH_PAGE_OFS = {
    16'h048a, 16'h0489, 16'h048b, 16'h0000,
    16'h0482, 16'h0481, 16'h0483, 16'h0487};
  localparam logic [7:0] PAGE_PRESENT = 8'hef;
  localparam logic [7:0] ALL_PRESENT  = 8'hff;
  // command ports, controller 1 then controller 0
  localparam logic [1:0][15:0] PTR_CLR_OFS = {16'h00d8, 16'h000c};
  localparam logic [1:0][15:0] MCLR_OFS    = {16'h00da, 16'h000d};

  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [7:0]  PAGE_RST    = 8'h00;
  localparam logic [15:0] COUNT_SPENT = 16'hffff;
  localparam logic [15:0] PAGE_STEP8  = 16'h0001;
  localparam logic [15:0] PAGE_STEP16 = 16'h0002;

  typedef struct packed {
    logic [7:0][15:0] cnt_base;
    logic [7:0][15:0] cnt_cur;
    logic [7:0][7:0]  lo_base;
    logic [7:0][7:0]  lo_cur;
    logic [7:0][7:0]  hi_base;
    logic [7:0][7:0]  hi_cur;
    logic [7:0]       ext_mode;
    logic [1:0]       byte_hi;
    logic [7:0]       rdata;
    logic             rd_valid;
    logic             tc_pulse;
    logic [2:0]       tc_chan;
    logic [31:0]      addr;
    logic             addr_valid;
    logic             mem_ok;
  } dcp_state_t;

  localparam dcp_state_t STATE_RST = '0;
endpackage : dcp_pkg

// file: hdl/dcp_step_if.sv
`timescale 1ns/10ps
interface dcp_step_if;
  logic [15:0] cnt_cur;
  logic [15:0] cnt_base;
  logic [1:0]  units;
  logic        autoinit;
  logic        eop;
  logic        chan16;
  logic        ext;
  logic        wrap;
  logic        down;
  logic [7:0]  hi_mask;
  logic [7:0]  lo_cur;
  logic [7:0]  hi_cur;
  logic [7:0]  lo_base;
  logic [7:0]  hi_base;
  logic [15:0] cnt_next;
  logic [7:0]  lo_next;
  logic [7:0]  hi_next;
  logic        tc;

  modport calc (input cnt_cur, cnt_base, units, autoinit, eop, chan16, ext, wrap, down,
                hi_mask, lo_cur, hi_cur, lo_base, hi_base,
                output cnt_next, lo_next, hi_next, tc);
  modport user (output cnt_cur, cnt_base, units, autoinit, eop, chan16, ext, wrap, down,
                hi_mask, lo_cur, hi_cur, lo_base, hi_base,
                input cnt_next, lo_next, hi_next, tc);
endinterface : dcp_step_if

// file: hdl/dcp_chan_step.sv
`timescale 1ns/10ps
module dcp_chan_step (
  dcp_step_if.calc s
);
  import dcp_pkg::*;

  logic [16:0] diff;
  logic [15:0] page;
  logic [15:0] step;
  logic        reload;

  // next count and page of the active channel
  always_comb begin
    diff = {1'b0, s.cnt_cur} - {15'h0000, s.units};
    s.tc = diff[16];
    page = {s.hi_cur, s.lo_cur};
    step = s.chan16 ? PAGE_STEP16 : PAGE_STEP8;
    // full carry only in extended mode
    if (s.ext && s.wrap) begin
      page = s.down ? page - step : page + step;
    end
    // narrow variant keeps low high-page bits
    page[15:8] = page[15:8] & s.hi_mask;
    reload = s.autoinit && (s.tc || s.eop);
    if (s.tc) begin
      s.cnt_next = s.autoinit ? s.cnt_base : COUNT_SPENT;
    end else begin
      s.cnt_next = diff[15:0];
    end
    s.lo_next = reload ? s.lo_base : page[7:0];
    // high page follows the same condition
    s.hi_next = reload ? (s.hi_base & s.hi_mask) : page[15:8];
  end
endmodule : dcp_chan_step

// file: hdl/dcp_count_page.sv
// Notes on behaviour
// - programmed count N gives N+1 transfers.
// - count decrements per transfer; wrap below zero raises expiry.
// - count reloads from base only on expiry.
// - without autoinit the count reads all ones after expiry.
// - 8-bit channels count bytes.
// - 16-bit shifted channels count words.
// - extended 16-bit I/O counts bytes, any count accepted.
// - chain mode loads reserve count into the base count.
// - reset or master clear zeroes base and current counts.
// - low page supplies address bits 23:16, or bits 23:17 from its bits 7:1 on 16-bit channels.
// - low page reloads from base on expiry or end of process.
// - high page is bits 31:24, or 26:24 in the narrow variant.
// - low page or address write clears high page.
// - high page left zero keeps compatibility addressing.
// - high page written last enables full-width carry.
// - memory strobes allowed only below 16 Mbytes.
// - high page reloads with the address on expiry or end.
// - chain mode loads reserve address bytes into base pages.
// - reset or master clear zeroes low and high pages.
// - first access after pointer clear is low byte, then high.
// - any write to pointer clear port selects low byte.
`timescale 1ns/10ps
module dcp_count_page #(
  parameter int ADDR_W = 32
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr_stb,
  input  wire logic        io_rd_stb,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_valid,
  output logic      [1:0]  byte_ptr_hi,
  input  wire logic        xfer_stb,
  input  wire logic [2:0]  xfer_chan,
  input  wire logic [1:0]  xfer_units,
  input  wire logic [15:0] cur_addr,
  input  wire logic        addr_wrap,
  input  wire logic        addr_down,
  input  wire logic [7:0]  autoinit_en,
  input  wire logic        end_of_process_signal,
  input  wire logic [2:0]  eop_chan,
  input  wire logic        sg_load_stb,
  input  wire logic [2:0]  sg_chan,
  input  wire logic [15:0] sg_count,
  input  wire logic [15:0] sg_page,
  output logic             count_expired,
  output logic      [2:0]  expired_chan,
  output logic      [31:0] dma_addr,
  output logic             dma_addr_valid,
  output logic             mem_strobe_ok,
  output logic      [7:0]  ext_mode_flags
);
  import dcp_pkg::*;

  // high page bits that exist in this variant
  localparam logic [7:0] HI_MASK = 8'(8'hff >> (32 - ADDR_W));

  dcp_state_t state_reg;
  dcp_state_t state_next;

  dcp_step_if step ();

  logic [2:0] act_chan;
  logic       act_stb;
  logic       act_eop;
  logic [3:0] hit_cnt;
  logic [3:0] hit_adr;
  logic [3:0] hit_lo;
  logic [3:0] hit_hi;

  // port lookup, returns {hit, channel}
  function automatic logic [3:0] dcp_find(
    input logic [15:0]       a,
    input logic [7:0][15:0]  tbl,
    input logic [7:0]        present
  );
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (present[i] && (a == tbl[i])) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : dcp_find

  // clear a whole controller's counts and pages
  function automatic dcp_state_t dcp_mclr(
    input dcp_state_t st,
    input logic       ctl
  );
    dcp_state_t o;
    o = st;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if ((i / 4) == int'(ctl)) begin
        o.cnt_base[i] = COUNT_RST;
        o.cnt_cur[i]  = COUNT_RST;
        o.lo_base[i]  = PAGE_RST;
        o.lo_cur[i]   = PAGE_RST;
        o.hi_base[i]  = PAGE_RST;
        o.hi_cur[i]   = PAGE_RST;
        o.ext_mode[i] = 1'b0;
      end
    end
    o.byte_hi[ctl] = 1'b0;
    return o;
  endfunction : dcp_mclr

  // port decode shared by reads and writes
  assign hit_cnt = dcp_find(io_addr, COUNT_OFS, ALL_PRESENT);
  assign hit_adr = dcp_find(io_addr, ADDR_OFS, ALL_PRESENT);
  assign hit_lo  = dcp_find(io_addr, LOW_PAGE_OFS, PAGE_PRESENT);
  assign hit_hi  = dcp_find(io_addr, HIGH_PAGE_OFS, PAGE_PRESENT);

  // a lone end of process uses its own channel; beside a transfer it acts only if on the transfer's channel
  assign act_chan = xfer_stb ? xfer_chan : eop_chan;
  assign act_stb  = xfer_stb || end_of_process_signal;
  assign act_eop  = end_of_process_signal && (eop_chan == act_chan);

  // feed the step unit from the active channel
  assign step.cnt_cur  = state_reg.cnt_cur[act_chan];
  assign step.cnt_base = state_reg.cnt_base[act_chan];
  // byte channels consume one unit per byte
  // shifted 16-bit channels one unit per word
  // extended 16-bit I/O passes bytes moved
  assign step.units    = xfer_stb ? xfer_units : 2'h0;
  assign step.autoinit = autoinit_en[act_chan];
  assign step.eop      = act_eop;
  assign step.chan16   = act_chan[2];
  assign step.ext      = state_reg.ext_mode[act_chan];
  assign step.wrap     = xfer_stb && addr_wrap;
  assign step.down     = addr_down;
  assign step.hi_mask  = HI_MASK;
  assign step.lo_cur   = state_reg.lo_cur[act_chan];
  assign step.hi_cur   = state_reg.hi_cur[act_chan];
  assign step.lo_base  = state_reg.lo_base[act_chan];
  assign step.hi_base  = state_reg.hi_base[act_chan];

  dcp_chan_step u_step (
    .s (step)
  );

  // next state: engine events first, software last so it wins
  always_comb begin
    logic       ctl;
    logic [2:0] c;
    logic       hb;
    ctl = 1'b0;
    c   = 3'h0;
    hb  = 1'b0;
    state_next = state_reg;
    state_next.rd_valid   = 1'b0;
    state_next.tc_pulse   = 1'b0;
    state_next.addr_valid = 1'b0;

    // address formed before the page moves
    if (xfer_stb) begin
      state_next.addr_valid = 1'b1;
      if (xfer_chan[2]) begin
        // 16-bit channels shift the address one place
        state_next.addr = {state_reg.hi_cur[xfer_chan],
                           state_reg.lo_cur[xfer_chan][7:1],
                           cur_addr, 1'b0};
      end else begin
        state_next.addr = {state_reg.hi_cur[xfer_chan],
                           state_reg.lo_cur[xfer_chan],
                           cur_addr};
      end
      state_next.mem_ok = (state_reg.hi_cur[xfer_chan] == PAGE_RST);
    end

    // expiry is the borrow past zero
    if (act_stb) begin
      state_next.cnt_cur[act_chan] = step.cnt_next;
      // without extended mode the page moves only on an autoinit reload
      state_next.lo_cur[act_chan]  = step.lo_next;
      state_next.hi_cur[act_chan]  = step.hi_next;
      if (step.tc && xfer_stb) begin
        state_next.tc_pulse = 1'b1;
        state_next.tc_chan  = act_chan;
      end
    end

    if (sg_load_stb) begin
      state_next.cnt_base[sg_chan] = sg_count;
      // reserve address bytes into base pages
      state_next.lo_base[sg_chan]  = sg_page[7:0];
      state_next.hi_base[sg_chan]  = sg_page[15:8] & HI_MASK;
    end

    if (io_wr_stb) begin
      if (hit_cnt[3]) begin
        c   = hit_cnt[2:0];
        ctl = c[2];
        hb  = state_reg.byte_hi[ctl];
        // low byte first, then high byte
        if (hb) begin
          state_next.cnt_base[c][15:8] = io_wdata;
          state_next.cnt_cur[c][15:8]  = io_wdata;
        end else begin
          state_next.cnt_base[c][7:0] = io_wdata;
          state_next.cnt_cur[c][7:0]  = io_wdata;
        end
        state_next.byte_hi[ctl] = ~hb;
      end else if (hit_adr[3]) begin
        c   = hit_adr[2:0];
        ctl = c[2];
        // pointer shared with the address port
        state_next.byte_hi[ctl] = ~state_reg.byte_hi[ctl];
        // address write drops the high page
        state_next.hi_base[c]  = PAGE_RST;
        state_next.hi_cur[c]   = PAGE_RST;
        state_next.ext_mode[c] = 1'b0;
      end else if (hit_lo[3]) begin
        c = hit_lo[2:0];
        state_next.lo_base[c]  = io_wdata;
        state_next.lo_cur[c]   = io_wdata;
        // low page write drops the high page
        state_next.hi_base[c]  = PAGE_RST;
        state_next.hi_cur[c]   = PAGE_RST;
        state_next.ext_mode[c] = 1'b0;
      end else if (hit_hi[3]) begin
        c = hit_hi[2:0];
        state_next.hi_base[c]  = io_wdata & HI_MASK;
        state_next.hi_cur[c]   = io_wdata & HI_MASK;
        // high page written last: extended mode
        state_next.ext_mode[c] = 1'b1;
      end else if (io_addr == PTR_CLR_OFS[0]) begin
        state_next.byte_hi[0] = 1'b0;
      end else if (io_addr == PTR_CLR_OFS[1]) begin
        state_next.byte_hi[1] = 1'b0;
      end else if (io_addr == MCLR_OFS[0]) begin
        state_next = dcp_mclr(state_next, 1'b0);
      end else if (io_addr == MCLR_OFS[1]) begin
        state_next = dcp_mclr(state_next, 1'b1);
      end
    end else if (io_rd_stb) begin
      if (hit_cnt[3]) begin
        c   = hit_cnt[2:0];
        ctl = c[2];
        hb  = state_reg.byte_hi[ctl];
        state_next.rdata = hb ? state_reg.cnt_cur[c][15:8]
                              : state_reg.cnt_cur[c][7:0];
        state_next.rd_valid     = 1'b1;
        state_next.byte_hi[ctl] = ~hb;
      end else if (hit_adr[3]) begin
        ctl = hit_adr[2];
        // address data comes from elsewhere; pointer still steps
        state_next.byte_hi[ctl] = ~state_reg.byte_hi[ctl];
      end else if (hit_lo[3]) begin
        state_next.rdata    = state_reg.lo_cur[hit_lo[2:0]];
        state_next.rd_valid = 1'b1;
      end else if (hit_hi[3]) begin
        // reserved high bits read as zero
        state_next.rdata    = state_reg.hi_cur[hit_hi[2:0]];
        state_next.rd_valid = 1'b1;
      end
    end
  end

  // single state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign io_rdata       = state_reg.rdata;
  assign io_rd_valid    = state_reg.rd_valid;
  assign byte_ptr_hi    = state_reg.byte_hi;
  assign count_expired  = state_reg.tc_pulse;
  assign expired_chan   = state_reg.tc_chan;
  assign dma_addr       = state_reg.addr;
  assign dma_addr_valid = state_reg.addr_valid;
  assign mem_strobe_ok  = state_reg.mem_ok;
  assign ext_mode_flags = state_reg.ext_mode;
endmodule : dcp_count_page

// file: verif/dcp_count_page_asserts.sv
`timescale 1ns/10ps
module dcp_count_page_asserts #(
  parameter int ADDR_W = 32
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr_stb,
  input wire logic        io_rd_stb,
  input wire logic        io_rd_valid,
  input wire logic [1:0]  byte_ptr_hi,
  input wire logic        xfer_stb,
  input wire logic [2:0]  xfer_chan,
  input wire logic        count_expired,
  input wire logic [2:0]  expired_chan,
  input wire logic [31:0] dma_addr,
  input wire logic        dma_addr_valid,
  input wire logic        mem_strobe_ok,
  input wire logic [7:0]  ext_mode_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // answers only ever follow their cause by one cycle
  property p_rd_ans; io_rd_valid |-> $past(io_rd_stb); endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer without request");
  property p_tc_src; count_expired |-> $past(xfer_stb) && expired_chan == $past(xfer_chan);
  endproperty
  a_tc_src: assert property (p_tc_src) else $error("expiry without transfer");
  property p_addr_ans; xfer_stb |=> dma_addr_valid; endproperty
  a_addr_ans: assert property (p_addr_ans) else $error("no address for transfer");
  property p_addr_src; $rose(dma_addr_valid) |-> $past(xfer_stb); endproperty
  a_addr_src: assert property (p_addr_src) else $error("address without transfer");
  property p_mem_ok; dma_addr_valid |-> mem_strobe_ok == (dma_addr[31:24] == 8'h00); endproperty
  a_mem_ok: assert property (p_mem_ok) else $error("memory strobe above 16M");
  // pointer and extended-mode side effects of the command, count and page ports
  property p_ptr0; io_wr_stb && io_addr == 16'h000c |=> !byte_ptr_hi[0]; endproperty
  a_ptr0: assert property (p_ptr0) else $error("pointer 0 not cleared");
  property p_ptr1; io_wr_stb && io_addr == 16'h00d8 |=> !byte_ptr_hi[1]; endproperty
  a_ptr1: assert property (p_ptr1) else $error("pointer 1 not cleared");
  property p_ptr_step;
    io_wr_stb && io_addr == 16'h0001 |=> byte_ptr_hi[0] != $past(byte_ptr_hi[0]);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
  property p_lo_clr; io_wr_stb && io_addr == 16'h0081 |=> !ext_mode_flags[2]; endproperty
  a_lo_clr: assert property (p_lo_clr) else $error("low page kept ext mode");
  property p_hi_set; io_wr_stb && io_addr == 16'h0481 |=> ext_mode_flags[2]; endproperty
  a_hi_set: assert property (p_hi_set) else $error("high page no ext mode");
  property p_mclr;
    io_wr_stb && io_addr == 16'h000d |=> ext_mode_flags[3:0] == 4'h0 && !byte_ptr_hi[0];
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear incomplete");
  c_tc: cover property (count_expired);
  c_rd: cover property (io_rd_valid);
  c_hi: cover property (dma_addr_valid && !mem_strobe_ok);
endmodule : dcp_count_page_asserts

bind dcp_count_page dcp_count_page_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// file: verif/dcp_isa_dev.sv
`timescale 1ns/10ps
module dcp_isa_dev (
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [2:0]  chan,
  input  wire logic [1:0]  units,
  input  wire logic        preset,
  input  wire logic [15:0] preset_addr,
  output logic             xfer_stb,
  output logic      [2:0]  xfer_chan,
  output logic      [1:0]  xfer_units,
  output logic      [15:0] cur_addr,
  output logic             addr_wrap
);
  logic [15:0] addr_reg;
  initial begin
    xfer_stb = 1'b0;
    addr_reg = 16'h0000;
  end
  // one transfer per cycle of go; idle lines invert so stale values never match
  always @(posedge ref_clk) begin
    xfer_stb   <= go;
    xfer_chan  <= go ? chan : ~chan;
    xfer_units <= go ? units : ~units;
    cur_addr   <= go ? addr_reg : ~addr_reg;
    addr_wrap  <= go && (addr_reg == 16'hffff);
    // preset lets a scenario start just below the 64k wrap
    if (preset) addr_reg <= preset_addr;
    else if (go) addr_reg <= addr_reg + 16'h0001;
  end
endmodule : dcp_isa_dev

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic        ref_clk, rst_n, io_wr_stb, io_rd_stb, go, sg_load_stb, io_rd_valid;
  logic        xfer_stb, addr_wrap, count_expired, dma_addr_valid, mem_strobe_ok;
  logic [15:0] io_addr, sg_count, sg_page, cur_addr;
  logic [7:0]  io_wdata, io_rdata, autoinit_en, ext_mode_flags;
  logic [1:0]  byte_ptr_hi, units, xfer_units;
  logic [2:0]  chan, sg_chan, xfer_chan, expired_chan, eop_chan;
  logic        eop, preset;
  logic [15:0] preset_addr;
  logic [31:0] dma_addr;
  int          num_errors, n_checks, tcs, nxf, t0;

  dcp_count_page #(.ADDR_W(32)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr_stb(io_wr_stb),
    .io_rd_stb(io_rd_stb), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rd_valid(io_rd_valid), .byte_ptr_hi(byte_ptr_hi), .xfer_stb(xfer_stb),
    .xfer_chan(xfer_chan), .xfer_units(xfer_units), .cur_addr(cur_addr),
    .addr_wrap(addr_wrap), .addr_down(1'b0), .autoinit_en(autoinit_en),
    .end_of_process_signal(eop), .eop_chan(eop_chan), .sg_load_stb(sg_load_stb),
    .sg_chan(sg_chan), .sg_count(sg_count), .sg_page(sg_page),
    .count_expired(count_expired), .expired_chan(expired_chan), .dma_addr(dma_addr),
    .dma_addr_valid(dma_addr_valid), .mem_strobe_ok(mem_strobe_ok),
    .ext_mode_flags(ext_mode_flags));
  dcp_isa_dev u_dev (
    .ref_clk(ref_clk), .go(go), .chan(chan), .units(units), .preset(preset),
    .preset_addr(preset_addr), .xfer_stb(xfer_stb),
    .xfer_chan(xfer_chan), .xfer_units(xfer_units), .cur_addr(cur_addr),
    .addr_wrap(addr_wrap));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // expiry pulses are counted here so tasks see every one
  always @(posedge ref_clk) if (count_expired === 1'b1) tcs++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr_stb = 1'b1;
    @(posedge ref_clk);
    #1 io_wr_stb = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic v);
    io_addr = a;
    io_rd_stb = 1'b1;
    @(posedge ref_clk);
    #1 io_rd_stb = 1'b0;
    chk(io_rd_valid, v);
    if (v) chk(io_rdata, e);
    @(posedge ref_clk);
    #1;
  endtask : rd
  // pointer 0 cleared first so the low byte always leads on controller 0 ports
  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    wr(16'h000c, 8'h00);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask : wr16
  task automatic rd16(input logic [15:0] a, input logic [15:0] e);
    wr(16'h000c, 8'h00);
    rd(a, e[7:0], 1'b1);
    rd(a, e[15:8], 1'b1);
  endtask : rd16
  task automatic run(input logic [2:0] c, input logic [1:0] u, input int n);
    chan = c;
    units = u;
    go = 1'b1;
    t0 = tcs;
    repeat (n) @(posedge ref_clk);
    #1 go = 1'b0;
    nxf += n;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : run

  task automatic t_reset;
    rd16(16'h0001, 16'h0000);
    rd(16'h0087, 8'h00, 1'b1);
    rd(16'h0487, 8'h00, 1'b1);
    rd(16'h0099, 8'h00, 1'b0);
  endtask : t_reset
  task automatic t_ptr;
    wr(16'h000c, 8'h5a);
    wr(16'h0005, 8'haa);
    chk(byte_ptr_hi[0], 1'b1);
    wr(16'h000c, 8'h33);
    chk(byte_ptr_hi[0], 1'b0);
    rd(16'h0005, 8'haa, 1'b1);
  endtask : t_ptr
  task automatic t_count;
    wr16(16'h0003, 16'h0002);
    run(3'd1, 2'd1, 2);
    chk(tcs - t0, 0);
    run(3'd1, 2'd1, 1);
    chk(tcs - t0, 1);
    chk(expired_chan, 3'd1);
    rd16(16'h0003, 16'hffff);
  endtask : t_count
  task automatic t_auto;
    autoinit_en = 8'h02;
    wr(16'h0083, 8'h05);
    wr16(16'h0003, 16'h0001);
    run(3'd1, 2'd1, 1);
    rd16(16'h0003, 16'h0000);
    run(3'd1, 2'd1, 1);
    chk(tcs - t0, 1);
    rd16(16'h0003, 16'h0001);
    rd(16'h0083, 8'h05, 1'b1);
    autoinit_en = 8'h00;
  endtask : t_auto
  task automatic t_units;
    wr16(16'h0001, 16'h0003);
    run(3'd0, 2'd3, 1);
    chk(tcs - t0, 0);
    run(3'd0, 2'd1, 1);
    chk(tcs - t0, 1);
  endtask : t_units
  task automatic t_page;
    wr(16'h0081, 8'h12);
    wr(16'h0481, 8'h34);
    chk(ext_mode_flags[2], 1'b1);
    run(3'd2, 2'd1, 1);
    chk(dma_addr, {8'h34, 8'h12, 16'(nxf - 1)});
    chk(mem_strobe_ok, 1'b0);
    wr(16'h0081, 8'h56);
    rd(16'h0481, 8'h00, 1'b1);
    run(3'd2, 2'd1, 1);
    chk(dma_addr, {8'h00, 8'h56, 16'(nxf - 1)});
    chk(mem_strobe_ok, 1'b1);
    wr(16'h008b, 8'h0f);
    run(3'd5, 2'd1, 1);
    chk(dma_addr, {8'h00, 7'h07, 16'(nxf - 1), 1'b0});
  endtask : t_page
  task automatic t_sg;
    autoinit_en = 8'h08;
    wr16(16'h0007, 16'h0005);
    sg_chan = 3'd3;
    sg_count = 16'h0002;
    sg_page = 16'h0033;
    sg_load_stb = 1'b1;
    @(posedge ref_clk);
    #1 sg_load_stb = 1'b0;
    rd16(16'h0007, 16'h0005);
    run(3'd3, 2'd1, 6);
    chk(tcs - t0, 1);
    rd16(16'h0007, 16'h0002);
    rd(16'h0082, 8'h33, 1'b1);
    autoinit_en = 8'h00;
  endtask : t_sg
  // park the far side's address counter at a chosen value
  task automatic seed(input logic [15:0] a);
    preset_addr = a;
    preset = 1'b1;
    @(posedge ref_clk);
    #1 preset = 1'b0;
  endtask : seed
  // extended carry across the 64k edge, end of process reload, compat mode
  task automatic t_wrap;
    autoinit_en = 8'h02;
    wr(16'h0083, 8'hff);
    wr(16'h0483, 8'h01);
    wr16(16'h0003, 16'h0005);
    seed(16'hffff);
    run(3'd1, 2'd1, 2);
    chk(dma_addr, {8'h02, 8'h00, 16'h0000});
    rd(16'h0083, 8'h00, 1'b1);
    eop_chan = 3'd1;
    eop = 1'b1;
    @(posedge ref_clk);
    #1 eop = 1'b0;
    rd16(16'h0003, 16'h0003);
    rd(16'h0483, 8'h01, 1'b1);
    rd(16'h0083, 8'hff, 1'b1);
    autoinit_en = 8'h00;
    wr(16'h0087, 8'h40);
    seed(16'hffff);
    run(3'd0, 2'd1, 2);
    chk(dma_addr, {8'h00, 8'h40, 16'h0000});
  endtask : t_wrap
  task automatic t_mclr;
    wr(16'h000d, 8'hc3);
    rd16(16'h0007, 16'h0000);
    rd(16'h0082, 8'h00, 1'b1);
    chk(ext_mode_flags[3:0], 4'h0);
  endtask : t_mclr

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial begin
    {rst_n, io_wr_stb, io_rd_stb, go, sg_load_stb} = '0;
    {io_addr, io_wdata, autoinit_en, units, chan} = '0;
    {sg_chan, sg_count, sg_page} = '0;
    {eop, preset, eop_chan, preset_addr} = '0;
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_reset;
    t_ptr;
    t_count;
    t_auto;
    t_units;
    t_page;
    t_sg;
    t_wrap;
    t_mclr;
    final_report;
  end
  // the tests need well under 2,000 cycles
  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule : tb
